// File: rtl/spac_pkg.sv
// Constants, code table and types shared by the servo alarm coder
//
// Summary of operation
// - Scale error bit n raises 51 sub n
// - Scale status alarm held until power-cycle; panel clear is only recorded
// - Broken scale A/B/Z wiring raises 55 sub 0..2
// - Current offset error raises 70, U=0, W=1
// - Thermal protector error raises 72 sub 0
// - Silent own-axis bus with execution right raises 80
// - Timeout period zero disables bus timeout alarm
// - Forced alarm input raises 87 sub 0
// - Semi-closed absolute recovery failure raises 92 sub 0
// - Full-closed absolute block recovery failure raises 92/1
// - Multi-turn limit mismatch raises 92 sub 3
// - Gear ratio out of range raises 93 sub 0
// - Block op without bus connection raises 93/0
// - Non-clearable alarms ignore clear input until power-cycle
`default_nettype none

package spac_pkg;

   // ==========================================================
   // Alarm sources and their codes
   // ==========================================================
   localparam int NUM_ALM = 19;
   localparam int NUM_SCALE = 6;

   typedef struct packed {
      logic [7:0] main_code;
      logic [7:0] sub_code;
   } spac_code_t;

   // Source index order is also the reporting priority (lowest first)
   localparam spac_code_t [NUM_ALM-1:0] ALM_TAB = {
      {8'h5D, 8'h00}, // 18: 93/0 block op without bus connection
      {8'h5D, 8'h00}, // 17: 93/0 gear ratio out of range
      {8'h5C, 8'h03}, // 16: 92/3 multi-turn limit mismatch
      {8'h5C, 8'h01}, // 15: 92/1 full-closed recovery failure
      {8'h5C, 8'h00}, // 14: 92/0 semi-closed recovery failure
      {8'h57, 8'h00}, // 13: 87/0 forced alarm
      {8'h50, 8'h00}, // 12: 80/0 bus timeout
      {8'h48, 8'h00}, // 11: 72/0 thermal protector
      {8'h46, 8'h01}, // 10: 70/1 W offset
      {8'h46, 8'h00}, //  9: 70/0 U offset
      {8'h37, 8'h02}, //  8: 55/2 Z wiring
      {8'h37, 8'h01}, //  7: 55/1 B wiring
      {8'h37, 8'h00}, //  6: 55/0 A wiring
      {8'h33, 8'h05}, {8'h33, 8'h04}, {8'h33, 8'h03},
      {8'h33, 8'h02}, {8'h33, 8'h01}, {8'h33, 8'h00} // 5..0: 51/n
   };

   // Sources that only a power-cycle (reset) removes
   localparam logic [NUM_ALM-1:0] NOCLR_MASK = 19'h001FF;

   // ==========================================================
   // Register map (byte addresses) and reset values
   // ==========================================================
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_TIMEOUT = 8'h04;
   localparam logic [7:0] OFS_GEAR_NUM = 8'h08;
   localparam logic [7:0] OFS_GEAR_DEN = 8'h0C;
   localparam logic [7:0] OFS_MTURN = 8'h10;
   localparam logic [7:0] OFS_ALM_STAT = 8'h14;
   localparam logic [7:0] OFS_CODE = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h20;
   localparam logic [7:0] OFS_IRQ_EN = 8'h24;

   localparam logic [15:0] RST_GEAR = 16'h0001;
   localparam logic [15:0] RST_MTURN = 16'hFFFF;
   localparam int CODE_VALID_BIT = 16;
   localparam int CODE_PANEL_BIT = 17;

   // Gear ratio limits with block operation active
   localparam logic [31:0] GEAR_MIN_DIV = 32'h0000_03E8; // 1/1000
   localparam logic [31:0] GEAR_MAX_MUL = 32'h0000_1F40; // 8000

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_NS = 1000000; // Timeout period unit: 1 ms
   localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// File: rtl/spac_bus_watchdog.sv
// Own-axis bus silence watchdog counting in timeout ticks
`default_nettype none

module spac_bus_watchdog
   import spac_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic exec_right,
   input wire logic frame_own,
   input wire logic [15:0] period,
   output logic expired
);

   initial
   begin
      if (TICK_CYCLES < 1)
         $error("TICK_CYCLES must be at least 1");
   end

   logic [31:0] pre_q;
   logic [15:0] cnt_q;
   logic armed;
   logic tick;

   // Zero period switches the watchdog off entirely
   assign armed = exec_right && (period != 16'h0000);
   assign tick = (pre_q == 32'(TICK_CYCLES - 1));

   // Prescaler restarts with every own-axis frame so silence is timed fully
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         pre_q <= 32'h0000_0000;
      else if (!armed || frame_own || tick)
         pre_q <= 32'h0000_0000;
      else
         pre_q <= pre_q + 32'h0000_0001;
   end

   // Silence counter in ticks; saturates at the period
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         cnt_q <= 16'h0000;
      else if (!armed || frame_own)
         cnt_q <= 16'h0000;
      else if (tick && cnt_q != period)
         cnt_q <= cnt_q + 16'h0001;
   end

   // Level while the silence has lasted the whole period
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         expired <= 1'b0;
      else
         expired <= armed && !frame_own && (cnt_q >= period);
   end

endmodule // spac_bus_watchdog

`default_nettype wire

// File: rtl/spac_alarm_coder.sv
// Servo protection alarm latch, coder and APB register file
`default_nettype none

module spac_alarm_coder
   import spac_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int MTURN_W = 16
)
(
   input wire logic mclk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Fault sources
   input wire logic [NUM_SCALE-1:0] scale_error_code,
   input wire logic [2:0] phase_broken,
   input wire logic [1:0] offset_err,
   input wire logic thermal_err,
   input wire logic exec_right,
   input wire logic frame_own,
   input wire logic forced_alarm,
   input wire logic semi_abs_init_fail,
   input wire logic full_abs_init_fail,
   input wire logic cont_rot_abs_mode,
   input wire logic [MTURN_W-1:0] enc_mturn_limit,
   input wire logic alarm_clear_input,
   input wire logic panel_scale_clear,
   // Reporting
   output logic alarm_active,
   output spac_code_t alarm_code,
   output logic irq
);

   initial
   begin
      if (MTURN_W < 1 || MTURN_W > 16)
         $error("MTURN_W must lie in 1..16");
      if (TICK_CYCLES < 1)
         $error("TICK_CYCLES must be at least 1");
      // Code table, clear mask and source vector share one layout
      if (NUM_ALM != NUM_SCALE + 13)
         $error("alarm table does not match the source vector");
   end

   // ==========================================================
   // Configuration registers
   // ==========================================================
   logic [7:0] block_op_setting_q;
   logic [7:0] bus_connection_setting_q;
   logic [15:0] comm_timeout_period_q;
   logic [15:0] gear_num_q;
   logic [15:0] gear_den_q;
   logic [MTURN_W-1:0] mturn_limit_q;
   logic [NUM_ALM-1:0] irq_en_q;

   // Alarm and interrupt state
   logic [NUM_ALM-1:0] alm_q;
   logic [NUM_ALM-1:0] irq_stat_q;
   logic panel_cleared_q;
   logic bus_expired;

   // APB decode
   logic acc;
   logic wr_en;
   logic hit;
   logic [31:0] rd_d;
   logic clr_wr;

   // Access completes on the second access cycle
   assign acc = psel && penable && !pready;
   assign wr_en = psel && penable && pready && pwrite;
   // Write-one-clear strobe; a same-cycle event still sets the bit
   assign clr_wr = wr_en && (paddr == OFS_IRQ_CLR);

   // Config writes take effect at the edge that samples pready high
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         block_op_setting_q <= 8'h00;
         bus_connection_setting_q <= 8'h00;
         comm_timeout_period_q <= 16'h0000;
         gear_num_q <= RST_GEAR;
         gear_den_q <= RST_GEAR;
         mturn_limit_q <= MTURN_W'(RST_MTURN);
         irq_en_q <= '0;
      end
      else if (wr_en)
      begin
         // Read-only and unmapped offsets fall to the default untouched
         unique case (paddr)
            OFS_CFG:
            begin
               block_op_setting_q <= pwdata[7:0];
               bus_connection_setting_q <= pwdata[15:8];
            end
            OFS_TIMEOUT: comm_timeout_period_q <= pwdata[15:0];
            OFS_GEAR_NUM: gear_num_q <= pwdata[15:0];
            OFS_GEAR_DEN: gear_den_q <= pwdata[15:0];
            OFS_MTURN: mturn_limit_q <= pwdata[MTURN_W-1:0];
            OFS_IRQ_EN: irq_en_q <= pwdata[NUM_ALM-1:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Fault detection
   // ==========================================================
   logic blk_on;
   logic [31:0] num_scaled;
   logic [31:0] den_scaled;
   logic gear_bad;
   logic mturn_bad;
   logic [NUM_ALM-1:0] src;

   assign blk_on = (block_op_setting_q != 8'h00);
   // Products fit 32 bits: 16-bit operand times a 13-bit limit
   assign num_scaled = 32'(gear_num_q) * GEAR_MIN_DIV;
   assign den_scaled = 32'(gear_den_q) * GEAR_MAX_MUL;
   // Zero terms are always invalid; the 1/1000..8000 window applies
   // only with block operation, which is where the host must keep it
   assign gear_bad = (gear_num_q == 16'h0000) || (gear_den_q == 16'h0000)
      || (blk_on && ((num_scaled < 32'(gear_den_q))
      || (32'(gear_num_q) > den_scaled)));
   assign mturn_bad = cont_rot_abs_mode
      && (enc_mturn_limit != mturn_limit_q);

   // Silence watchdog; a zero period keeps it idle
   spac_bus_watchdog #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_wdog (
      .mclk(mclk),
      .rst(rst),
      .exec_right(exec_right),
      .frame_own(frame_own),
      .period(comm_timeout_period_q),
      .expired(bus_expired)
   );

   // Source vector in table order; the index is also the priority
   // Scale status bits sit at 0..5, wiring A, B, Z at 6..8
   assign src[NUM_SCALE-1:0] = scale_error_code;
   assign src[8:6] = phase_broken;
   // Offset U then W, then thermal, bus silence and forced alarm
   assign src[10:9] = offset_err;
   assign src[11] = thermal_err;
   assign src[12] = bus_expired;
   assign src[13] = forced_alarm;
   // The full-closed recovery check only counts with block operation
   assign src[14] = semi_abs_init_fail;
   assign src[15] = full_abs_init_fail && blk_on;
   assign src[16] = mturn_bad;
   // Both setup faults report 93/0 but keep separate status bits
   assign src[17] = gear_bad;
   assign src[18] = blk_on && (bus_connection_setting_q == 8'h00);

   // ==========================================================
   // Alarm latches
   // ==========================================================
   // A present cause always wins over the clear input, so an event in
   // the clearing cycle is kept; masked sources only leave on reset
   // Limitation: a cause still present keeps its alarm latched through any clear
   genvar gi;
   generate
      for (gi = 0; gi < NUM_ALM; gi++)
      begin : g_alm
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
               alm_q[gi] <= 1'b0;
            else if (src[gi])
               alm_q[gi] <= 1'b1;
            else if (alarm_clear_input && !NOCLR_MASK[gi])
               alm_q[gi] <= 1'b0;
         end

         // Interrupt status marks each new latch; write-one clears
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
               irq_stat_q[gi] <= 1'b0;
            else if (src[gi] && !alm_q[gi])
               irq_stat_q[gi] <= 1'b1;
            else if (clr_wr && pwdata[gi])
               irq_stat_q[gi] <= 1'b0;
         end
      end
   endgenerate

   // Panel clear of a scale status fault is only recorded; the alarm
   // itself stays until the following power-cycle
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         panel_cleared_q <= 1'b0;
      else if (panel_scale_clear && (alm_q[NUM_SCALE-1:0] != '0))
         panel_cleared_q <= 1'b1;
   end

   // ==========================================================
   // Code reporting
   // ==========================================================
   spac_code_t code_d;
   logic any_d;

   // Lowest active index is reported first
   // The loop runs downward, so the last hit is the lowest index
   always_comb
   begin
      code_d = '0;
      any_d = 1'b0;
      for (int i = NUM_ALM - 1; i >= 0; i--)
      begin
         if (alm_q[i])
         begin
            code_d = ALM_TAB[i];
            any_d = 1'b1;
         end
      end
   end

   // Outputs are registered so a host never sees a half-updated pair
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         alarm_code <= '0;
         alarm_active <= 1'b0;
      end
      else
      begin
         alarm_code <= code_d;
         alarm_active <= any_d;
      end
   end

   // Level interrupt while any enabled status bit is set
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(irq_stat_q & irq_en_q);
   end

   // ==========================================================
   // APB read path and handshake
   // ==========================================================
   always_comb
   begin
      rd_d = 32'h0000_0000;
      hit = 1'b1;
      unique case (paddr)
         OFS_CFG: rd_d = {16'h0000, bus_connection_setting_q, block_op_setting_q};
         OFS_TIMEOUT: rd_d = {16'h0000, comm_timeout_period_q};
         OFS_GEAR_NUM: rd_d = {16'h0000, gear_num_q};
         OFS_GEAR_DEN: rd_d = {16'h0000, gear_den_q};
         OFS_MTURN: rd_d = 32'(mturn_limit_q);
         OFS_ALM_STAT: rd_d = 32'(alm_q);
         // Bit 17 tells software that only a power-cycle remains
         OFS_CODE:
         begin
            rd_d = {16'h0000, alarm_code};
            rd_d[CODE_VALID_BIT] = alarm_active;
            rd_d[CODE_PANEL_BIT] = panel_cleared_q;
         end
         OFS_IRQ_STAT: rd_d = 32'(irq_stat_q);
         OFS_IRQ_CLR: rd_d = 32'h0000_0000; // Write-only
         OFS_IRQ_EN: rd_d = 32'(irq_en_q);
         default: hit = 1'b0;
      endcase
   end

   // One wait state; unmapped addresses answer with an error
   // prdata holds after the access so a slow master still sees it
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= acc;
         pslverr <= acc && !hit;
         if (acc && !pwrite)
            prdata <= rd_d;
      end
   end

endmodule // spac_alarm_coder

`default_nettype wire

// File: sim/spac_alarm_coder_chk.sv
// Port checker for the servo alarm coder, bound to its top
`default_nettype none

module spac_alarm_coder_chk
   import spac_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [NUM_SCALE-1:0] scale_error_code,
   input wire logic [2:0] phase_broken,
   input wire logic [1:0] offset_err,
   input wire logic thermal_err,
   input wire logic forced_alarm,
   input wire logic alarm_clear_input,
   input wire logic alarm_active,
   input wire spac_code_t alarm_code
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // Properties
   // ==========================================================
   // Causes that outrank the thermal alarm
   logic hi_src;
   assign hi_src = |{scale_error_code, phase_broken, offset_err};

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   // Fresh single cause: past value zero keeps a stale latch from winning
   property scale_code_p;
      $onehot(scale_error_code) && $past(scale_error_code) == 6'h00 && !alarm_active
         |-> ##2 alarm_code.main_code == 8'h33
         && (6'h01 << alarm_code.sub_code) == $past(scale_error_code, 2);
   endproperty

   property phase_code_p;
      $onehot(phase_broken) && $past(phase_broken) == 3'h0 && scale_error_code == 6'h00
         && $past(scale_error_code) == 6'h00 && !alarm_active
         |-> ##2 alarm_code.main_code == 8'h37
         && (3'h1 << alarm_code.sub_code) == $past(phase_broken, 2);
   endproperty

   apb_answer_a: assert property (
      psel && !penable ##1 psel && penable |=> pready
      && pslverr == ($past(paddr) > OFS_IRQ_EN || $past(paddr[1:0]) != 2'h0))
      else $error("bus answer late or error flag wrong");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   scale_code_a: assert property (scale_code_p)
      else $error("scale status code wrong");
   phase_code_a: assert property (phase_code_p)
      else $error("wiring code wrong");
   nocl_hold_a: assert property (
      alarm_active && alarm_code.main_code inside {8'h33, 8'h37}
      |=> alarm_active && alarm_code.main_code inside {8'h33, 8'h37})
      else $error("non-clearable alarm dropped");
   thermal_code_a: assert property (
      thermal_err && !hi_src && !$past(hi_src) && !alarm_active |-> ##2 alarm_code == 16'h4800)
      else $error("thermal code wrong");
   forced_seen_a: assert property (forced_alarm |-> ##2 alarm_active)
      else $error("forced alarm not raised");
   clear_refused_a: assert property (
      forced_alarm && alarm_active && alarm_clear_input |=> alarm_active)
      else $error("clear won over live cause");

   cover property (pslverr);
   cover property (alarm_code == 16'h5000);
   cover property (alarm_clear_input && alarm_active);

endmodule // spac_alarm_coder_chk

bind spac_alarm_coder spac_alarm_coder_chk chk_i (.mclk, .rst, .psel, .penable, .paddr,
   .pready, .pslverr, .scale_error_code, .phase_broken, .offset_err, .thermal_err,
   .forced_alarm, .alarm_clear_input, .alarm_active, .alarm_code);

`default_nettype wire

// File: sim/spac_far_model.sv
// Far side model: scale, sensors, encoder and host frame source
`default_nettype none

module spac_far_model
   import spac_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [15:0] want,
   input wire logic talk,
   input wire logic slow,
   output logic [NUM_SCALE-1:0] scale_error_code,
   output logic [2:0] phase_broken,
   output logic [1:0] offset_err,
   output logic thermal_err,
   output logic forced_alarm,
   output logic semi_abs_init_fail,
   output logic full_abs_init_fail,
   output logic cont_rot_abs_mode,
   output logic [15:0] enc_mturn_limit,
   output logic frame_own
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [15:0] want_q;
   logic [3:0] gap_q;

   // Fault levels lag the request by one edge, as a real sensor would
   always_ff @(posedge mclk or posedge rst)
      if (rst)
         want_q <= 16'h0000;
      else
         want_q <= want;

   assign {cont_rot_abs_mode, full_abs_init_fail, semi_abs_init_fail, forced_alarm,
      thermal_err, offset_err, phase_broken, scale_error_code} = want_q;
   // Encoder limit never matches the default setting, so mode alone gates it
   assign enc_mturn_limit = 16'h0005;

   // Own-axis frames every 4 or 10 cycles; slow still beats a 12 cycle limit
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         gap_q <= 4'h0;
         frame_own <= 1'b0;
      end
      else
      begin
         frame_own <= talk && gap_q == 4'h0;
         gap_q <= (gap_q == 4'h0) ? (slow ? 4'h9 : 4'h3) : gap_q - 4'h1;
      end

endmodule // spac_far_model

`default_nettype wire

// File: sim/spac_alarm_coder_bench.sv
// Self-checking bench for the servo alarm coder
`default_nettype none

module spac_alarm_coder_bench
   import spac_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic mclk, rst, psel, penable, pwrite, pready, pslverr, serr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic exec_right, alarm_clear_input, panel_scale_clear, talk, slow, frame_own;
   logic alarm_active, irq, thermal_err, forced_alarm;
   logic semi_abs_init_fail, full_abs_init_fail, cont_rot_abs_mode;
   logic [NUM_SCALE-1:0] scale_error_code;
   logic [2:0] phase_broken;
   logic [1:0] offset_err;
   logic [15:0] enc_mturn_limit, want;
   spac_code_t alarm_code;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;

   // Expected code per request bit of the far side model
   localparam logic [15:0] EXP [16] = '{16'h3300, 16'h3301, 16'h3302, 16'h3303,
      16'h3304, 16'h3305, 16'h3700, 16'h3701, 16'h3702, 16'h4600, 16'h4601, 16'h4800,
      16'h5700, 16'h5C00, 16'h5C01, 16'h5C03};
   // Configuration rows: setting word, gear numerator, denominator, alarm expected
   localparam logic [31:0] CFG_R [7] = '{32'h0101, 32'h0101, 32'h0101, 32'h0101,
      32'h0001, 32'h0000, 32'h0000};
   localparam logic [31:0] NUM_R [7] = '{32'h1, 32'h1, 32'h1F40, 32'h1F41, 32'h1, 32'h0,
      32'h1F41};
   localparam logic [31:0] DEN_R [7] = '{32'h3E8, 32'h3E9, 32'h1, 32'h1, 32'h1, 32'h1,
      32'h1};
   localparam logic [6:0] ALM_R = 7'h3A;

   // ==========================================================
   // Design, far side and clock
   // ==========================================================
   spac_alarm_coder #(.TICK_CYCLES(4)) uut (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .scale_error_code, .phase_broken, .offset_err,
      .thermal_err, .exec_right, .frame_own, .forced_alarm, .semi_abs_init_fail,
      .full_abs_init_fail, .cont_rot_abs_mode, .enc_mturn_limit, .alarm_clear_input,
      .panel_scale_clear, .alarm_active, .alarm_code, .irq);

   spac_far_model far (.mclk, .rst, .want, .talk, .slow, .scale_error_code, .phase_broken,
      .offset_err, .thermal_err, .forced_alarm, .semi_abs_init_fail, .full_abs_init_fail,
      .cont_rot_abs_mode, .enc_mturn_limit, .frame_own);

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // Hang guard: the whole run needs about a thousand cycles
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         bad_count++;
         conclude();
      end
   end

   // ==========================================================
   // Shared tasks
   // ==========================================================
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e)
      begin
         $display("wrong value %s expected %h seen %h", nm, e, s);
         bad_count++;
      end
   endtask

   // Reads see pre-edge values, so the answer is taken at its sampling edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
         @(posedge mclk);
      while (pready !== 1'b1);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic restart();
      rst <= 1'b1;
      want <= 16'h0000;
      exec_right <= 1'b0;
      talk <= 1'b0;
      alarm_clear_input <= 1'b0;
      panel_scale_clear <= 1'b0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_regs();
      restart();
      apb(1'b0, OFS_GEAR_NUM, 32'h0);
      check("gear reset", 32'h1, rd);
      apb(1'b0, OFS_MTURN, 32'h0);
      check("mturn reset", 32'hFFFF, rd);
      apb(1'b1, OFS_IRQ_EN, 32'h5);
      apb(1'b0, OFS_IRQ_EN, 32'h0);
      check("irq enable", 32'h5, rd);
      apb(1'b1, OFS_ALM_STAT, 32'h3FFFF);
      apb(1'b0, OFS_ALM_STAT, 32'h0);
      check("status read only", 32'h0, rd);
      apb(1'b0, 8'h28, 32'h0);
      check("unmapped error", 32'h1, {31'h0, serr});
      $display("register test done");
   endtask

   // Each of the 16 far side request bits alone: code, irq mask, refused clear, who may be cleared
   task automatic t_sources();
      logic [31:0] exp_w, got_w;
      for (int k = 0; k < 16; k++)
      begin
         restart();
         if (k == 14)
            apb(1'b1, OFS_CFG, 32'h0101);
         want <= 16'h1 << k;
         repeat (4) @(posedge mclk);
         exp_w = {16'h0, EXP[k]};
         got_w = {16'h0, alarm_code};
         check("main code", exp_w & 32'hFF00, got_w & 32'hFF00);
         check("sub code", exp_w & 32'hFF, got_w & 32'hFF);
         check("masked irq", 32'h0, {31'h0, irq});
         apb(1'b1, OFS_IRQ_EN, 32'hFFFFFFFF);
         repeat (2) @(posedge mclk);
         check("irq", 32'h1, {31'h0, irq});
         alarm_clear_input <= 1'b1;
         panel_scale_clear <= 1'b1;
         repeat (3) @(posedge mclk);
         check("clear refused", 32'h1, {31'h0, alarm_active});
         want <= 16'h0000;
         repeat (4) @(posedge mclk);
         alarm_clear_input <= 1'b0;
         panel_scale_clear <= 1'b0;
         check("after clear", {31'h0, k < 9}, {31'h0, alarm_active});
         if (k < 6)
         begin
            apb(1'b0, OFS_CODE, 32'h0);
            check("code word", {16'h3, EXP[k]}, rd);
         end
         apb(1'b1, OFS_IRQ_CLR, 32'hFFFFFFFF);
         repeat (2) @(posedge mclk);
         check("irq cleared", 32'h0, {31'h0, irq});
      end
      $display("source test done");
   endtask

   task automatic t_config();
      for (int r = 0; r < 7; r++)
      begin
         restart();
         apb(1'b1, OFS_CFG, CFG_R[r]);
         apb(1'b1, OFS_GEAR_NUM, NUM_R[r]);
         apb(1'b1, OFS_GEAR_DEN, DEN_R[r]);
         alarm_clear_input <= 1'b1;
         repeat (4) @(posedge mclk);
         alarm_clear_input <= 1'b0;
         repeat (3) @(posedge mclk);
         check("setup alarm", 32'(ALM_R[r]), 32'(alarm_active));
         if (ALM_R[r])
            check("setup code", 32'h5D00, {16'h0, alarm_code});
      end
      $display("config test done");
   endtask

   task automatic t_watch();
      restart();
      apb(1'b1, OFS_TIMEOUT, 32'h3);
      exec_right <= 1'b1;
      talk <= 1'b1;
      slow <= 1'b1;
      repeat (60) @(posedge mclk);
      check("frames arriving", 32'h0, {31'h0, alarm_active});
      talk <= 1'b0;
      repeat (30) @(posedge mclk);
      check("silence code", 32'h5000, {16'h0, alarm_code});
      restart();
      apb(1'b1, OFS_TIMEOUT, 32'h3);
      repeat (60) @(posedge mclk);
      check("no right", 32'h0, {31'h0, alarm_active});
      exec_right <= 1'b1;
      apb(1'b1, OFS_TIMEOUT, 32'h0);
      repeat (60) @(posedge mclk);
      check("zero period", 32'h0, {31'h0, alarm_active});
      $display("watchdog test done");
   endtask

   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      want = 16'h0000;
      exec_right = 1'b0;
      alarm_clear_input = 1'b0;
      panel_scale_clear = 1'b0;
      talk = 1'b0;
      slow = 1'b0;
      t_regs();
      t_sources();
      t_config();
      t_watch();
      conclude();
   end

endmodule // spac_alarm_coder_bench

`default_nettype wire
